// *** sdbs_pkg.sv ***
/*
  sdbs_pkg: constants shared by the burst sequencing block.
  Holds register offsets, mode field positions, codes and reset values.
  Assumes a 32-bit software port with byte offsets.
*/
package sdbs_pkg;

  // register offsets, byte addresses
  localparam logic [7:0] SDBS_REG_MODE_OFS = 8'h00;
  localparam logic [7:0] SDBS_REG_STAT_OFS = 8'h04;

  // mode register field positions
  localparam int SDBS_BL_POS = 0;
  localparam int SDBS_BL_W = 3;
  localparam int SDBS_BO_POS = 3;
  localparam int SDBS_LAT_POS = 4;
  localparam int SDBS_LAT_W = 3;
  localparam int SDBS_OPL_POS = 7;
  localparam int SDBS_OPH_POS = 8;
  localparam int SDBS_WSA_POS = 9;
  localparam int SDBS_MODE_W = 10;

  // mode reset value: length one, sequential, latency two, normal
  localparam logic [9:0] SDBS_MODE_RST = 10'h020;

  // burst length codes
  localparam logic [2:0] SDBS_BL_ONE = 3'h0;
  localparam logic [2:0] SDBS_BL_TWO = 3'h1;
  localparam logic [2:0] SDBS_BL_FOUR = 3'h2;
  localparam logic [2:0] SDBS_BL_EIGHT = 3'h3;
  localparam logic [2:0] SDBS_BL_PAGE = 3'h7;

  // latency codes and the cycle counts they stand for
  localparam logic [2:0] SDBS_LAT_TWO = 3'h2;
  localparam logic [2:0] SDBS_LAT_THREE = 3'h3;
  localparam int SDBS_LAT_TWO_CYC = 2;
  localparam int SDBS_LAT_THREE_CYC = 3;

  // status register field positions
  localparam int SDBS_ST_ACT_POS = 0;
  localparam int SDBS_ST_WR_POS = 1;
  localparam int SDBS_ST_OPBAD_POS = 2;
  localparam int SDBS_ST_BLBAD_POS = 3;
  localparam int SDBS_ST_OE_POS = 4;
  localparam int SDBS_ST_COL_POS = 16;

  // burst engine states, one-hot
  typedef enum logic [2:0] {
    SDBS_IDLE = 3'b001,
    SDBS_RD = 3'b010,
    SDBS_WR = 3'b100
  } sdbs_state_type;

endpackage

// *** sdbs_col_seq.sv ***
/*
  sdbs_col_seq: column of the k-th access of a burst.
  Assumes the caller supplies the in-block mask and ordering select.
*/
`timescale 1ns/1ps
module sdbs_col_seq import sdbs_pkg::*; #(
  parameter int COL_W = 9
) (
  // burst description
  input wire logic [COL_W-1:0] start_col,
  input wire logic [COL_W-1:0] step_idx,
  input wire logic [COL_W-1:0] blk_mask,
  input wire logic ilv_sel,
  // resulting column
  output logic [COL_W-1:0] col
);

  logic [COL_W-1:0] seq_off;
  logic [COL_W-1:0] ilv_off;

  // sequential adds the step, interleaved xors it
  assign seq_off = start_col + step_idx;
  assign ilv_off = start_col ^ step_idx;

  // masked bits move, upper bits keep the block
  for (genvar i = 0; i < COL_W; i++) begin : g_bit
    assign col[i] = blk_mask[i] ? (ilv_sel ? ilv_off[i] : seq_off[i])
                                : start_col[i];
  end

endmodule // sdbs_col_seq

// *** sdbs_col_mem.sv ***
/*
  sdbs_col_mem: one page of column storage with registered read data.
  Assumes one access per cycle; writes and reads share the address.
*/
`timescale 1ns/1ps
module sdbs_col_mem import sdbs_pkg::*; #(
  parameter int ADDR_W = 9,
  parameter int DATA_W = 16
) (
  // clocking
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // access port
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem_arr [2**ADDR_W];

  // array write
  always_ff @(posedge clock) begin
    if (clk_en && wr_en) begin
      mem_arr[addr] <= wdata;
    end
  end

  // registered read
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (clk_en) begin
      rdata <= mem_arr[addr];
    end
  end

endmodule // sdbs_col_mem

// *** sdbs_top.sv ***
/*
  sdbs_top: column burst sequencing and read latency of a sync DRAM page.
  Assumes commands are one-cycle pulses sampled on the rising clock edge,
  write data arrive with each write edge, and software owns the mode word.
*/
// Design decisions made here: the strobed register port and the placing of the registers.
// What this block does
// - burst lengths one, two, four, eight both orders
// - full page sequential only, terminate cuts burst
// - burst length caps columns per command
// - accesses stay inside aligned block, wrapping
// - upper column bits pick the block
// - low column bits give starting offset
// - full page advances sequentially, wraps in page
// - one mode bit selects burst order
// - sequential steps modulo length from start
// - interleaved access is start xor index
// - read latency two or three cycles
// - first read word valid at n plus m
// - outputs start driving one edge earlier
// - read and write accepted only in normal operating mode, terminate in any mode
// - write single bit clear, length governs both
// - write single bit set, writes single column
`timescale 1ns/1ps
module sdbs_top import sdbs_pkg::*; #(
  parameter int COL_W = 9,
  parameter int DQ_W = 16
) (
  // clocking
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff,
  // commands
  input wire logic cmd_read,
  input wire logic cmd_write,
  input wire logic cmd_term,
  input wire logic [COL_W-1:0] cmd_col,
  // data pins
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out_ff,
  output logic dq_oe_ff
);

  localparam logic [COL_W:0] LEN_PAGE = {1'b1, {COL_W{1'b0}}};
  localparam logic [COL_W:0] LEN_ONE = (COL_W+1)'(1);
  logic [SDBS_MODE_W-1:0] mode_ff;
  sdbs_state_type state_ff, nxt_state;
  logic [COL_W-1:0] start_ff, mask_ff, burst_mask, cur_col, mem_addr;
  logic [COL_W:0] idx_ff, len_ff, words_ff, burst_len, nxt_len;
  logic [DQ_W-1:0] data_d_ff, mem_rdata;
  logic [2:0] bl_code, lat_code;
  logic ilv_ff, lat3_ff, iss_ff, iss_d_ff, op_normal, wsa_sel, page_sel;
  logic ilv_sel, lat3_sel, bl_bad, rd_go, wr_go, rd_issue, wr_issue, burst_act;
  // mode field decode
  assign bl_code = mode_ff[SDBS_BL_POS +: SDBS_BL_W];
  assign lat_code = mode_ff[SDBS_LAT_POS +: SDBS_LAT_W];
  assign op_normal = !mode_ff[SDBS_OPL_POS] && !mode_ff[SDBS_OPH_POS];
  assign wsa_sel = mode_ff[SDBS_WSA_POS];
  assign page_sel = (bl_code == SDBS_BL_PAGE);
  // full page never interleaves
  assign ilv_sel = mode_ff[SDBS_BO_POS] && !page_sel;
  // reserved latency codes fall back to three
  assign lat3_sel = (lat_code != SDBS_LAT_TWO);

  // burst length and in-block mask from the length field
  always_comb begin
    burst_len = LEN_ONE;
    burst_mask = '0;
    bl_bad = 1'b0;
    case (bl_code)
      SDBS_BL_ONE: begin
        burst_len = LEN_ONE;
        burst_mask = '0;
      end
      SDBS_BL_TWO: begin
        burst_len = (COL_W+1)'(2);
        burst_mask = COL_W'(1);
      end
      SDBS_BL_FOUR: begin
        burst_len = (COL_W+1)'(4);
        burst_mask = COL_W'(3);
      end
      SDBS_BL_EIGHT: begin
        burst_len = (COL_W+1)'(8);
        burst_mask = COL_W'(7);
      end
      SDBS_BL_PAGE: begin
        burst_len = LEN_PAGE;
        burst_mask = '1;
      end
      default: begin
        // reserved lengths act as single access
        bl_bad = 1'b1;
      end
    endcase
  end

  // command qualification
  assign rd_go = cmd_read && op_normal;
  assign wr_go = cmd_write && !cmd_read && op_normal;
  assign burst_act = (state_ff != SDBS_IDLE);
  // writes shrink to one column when the single bit is set
  assign nxt_len = (wr_go && wsa_sel) ? LEN_ONE : burst_len;

  // next burst state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SDBS_IDLE, SDBS_RD, SDBS_WR: begin
        if (rd_go || wr_go) begin
          if (nxt_len == LEN_ONE) begin
            nxt_state = SDBS_IDLE;
          end else if (rd_go) begin
            nxt_state = SDBS_RD;
          end else begin
            nxt_state = SDBS_WR;
          end
        end else if (cmd_term) begin
          nxt_state = SDBS_IDLE;
        end else if (burst_act && (idx_ff + LEN_ONE == len_ff)) begin
          nxt_state = SDBS_IDLE;
        end
      end
      default: begin
        nxt_state = SDBS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= SDBS_IDLE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // burst description captured at the command edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      start_ff <= '0;
      len_ff <= LEN_ONE;
      mask_ff <= '0;
      ilv_ff <= 1'b0;
    end else if (clk_en && (rd_go || wr_go)) begin
      start_ff <= cmd_col;
      len_ff <= nxt_len;
      mask_ff <= (wr_go && wsa_sel) ? '0 : burst_mask;
      ilv_ff <= ilv_sel;
    end
  end

  // access index steps once per edge while the burst runs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      idx_ff <= '0;
    end else if (clk_en) begin
      if (rd_go || wr_go) begin
        idx_ff <= LEN_ONE;
      end else if (burst_act) begin
        idx_ff <= idx_ff + LEN_ONE;
      end
    end
  end

  // latency held per read burst
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lat3_ff <= 1'b0;
    end else if (clk_en && rd_go) begin
      lat3_ff <= lat3_sel;
    end
  end

  // column of the access in flight
  sdbs_col_seq #(
    .COL_W(COL_W)
  ) u_seq (
    .start_col(start_ff),
    .step_idx(idx_ff[COL_W-1:0]),
    .blk_mask(mask_ff),
    .ilv_sel(ilv_ff),
    .col(cur_col)
  );

  // the command cycle addresses its own column directly
  assign mem_addr = (rd_go || wr_go) ? cmd_col : cur_col;
  assign wr_issue = wr_go || (state_ff == SDBS_WR && !cmd_term && !rd_go);
  assign rd_issue = rd_go || (state_ff == SDBS_RD && !cmd_term && !wr_go);

  // page column storage
  sdbs_col_mem #(
    .ADDR_W(COL_W),
    .DATA_W(DQ_W)
  ) u_mem (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .wr_en(wr_issue),
    .addr(mem_addr),
    .wdata(dq_in),
    .rdata(mem_rdata)
  );

  // read pipeline, one extra stage for latency three
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      iss_ff <= 1'b0;
      iss_d_ff <= 1'b0;
      data_d_ff <= '0;
    end else if (clk_en) begin
      iss_ff <= rd_issue;
      iss_d_ff <= iss_ff;
      data_d_ff <= mem_rdata;
    end
  end

  // output drive, set one edge before the data are sampled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dq_oe_ff <= 1'b0;
      dq_out_ff <= '0;
    end else if (clk_en) begin
      if (lat3_ff) begin
        dq_oe_ff <= iss_d_ff;
        dq_out_ff <= iss_d_ff ? data_d_ff : '0;
      end else begin
        dq_oe_ff <= iss_ff;
        dq_out_ff <= iss_ff ? mem_rdata : '0;
      end
    end
  end

  // accesses issued in the current burst
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      words_ff <= '0;
    end else if (clk_en) begin
      if (rd_go || wr_go) begin
        words_ff <= LEN_ONE;
      end else if (rd_issue || wr_issue) begin
        words_ff <= words_ff + LEN_ONE;
      end
    end
  end

  // mode register write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_ff <= SDBS_MODE_RST;
    end else if (clk_en && reg_wr && reg_addr == SDBS_REG_MODE_OFS) begin
      mode_ff <= reg_wdata[SDBS_MODE_W-1:0];
    end
  end

  // register read, data stand only the cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= '0;
    end else if (clk_en) begin
      reg_rdata_ff <= '0;
      if (reg_rd && reg_addr == SDBS_REG_MODE_OFS) begin
        reg_rdata_ff[SDBS_MODE_W-1:0] <= mode_ff;
      end else if (reg_rd && reg_addr == SDBS_REG_STAT_OFS) begin
        reg_rdata_ff[SDBS_ST_ACT_POS] <= burst_act;
        reg_rdata_ff[SDBS_ST_WR_POS] <= (state_ff == SDBS_WR);
        reg_rdata_ff[SDBS_ST_OPBAD_POS] <= !op_normal;
        reg_rdata_ff[SDBS_ST_BLBAD_POS] <= bl_bad;
        reg_rdata_ff[SDBS_ST_OE_POS] <= dq_oe_ff;
        reg_rdata_ff[SDBS_ST_COL_POS +: COL_W] <= cur_col;
      end
    end
  end

  // first read word, latency two, idle pipe
  chk_lat_two: assert property (
    @(posedge clock) disable iff (rst || !clk_en)
    rd_go && !lat3_sel && !iss_ff && !iss_d_ff
      |-> ##1 !dq_oe_ff ##1 dq_oe_ff)
    else $error("latency two read drove data at the wrong edge");

  // first read word, latency three, idle pipe
  chk_lat_three: assert property (
    @(posedge clock) disable iff (rst || !clk_en)
    rd_go && lat3_sel && !iss_ff && !iss_d_ff
      |-> ##2 !dq_oe_ff ##1 dq_oe_ff)
    else $error("latency three read drove data at the wrong edge");

  // the block address bits never move inside a burst
  chk_block_wrap: assert property (
    @(posedge clock) disable iff (rst || !clk_en)
    burst_act |-> ((cur_col & ~mask_ff) == (start_ff & ~mask_ff)))
    else $error("burst column left its block");

  // start column register holds the commanded column after the command edge
  chk_start_col: assert property (
    @(posedge clock) disable iff (rst || !clk_en)
    (rd_go || wr_go) |-> ##1 (start_ff == $past(cmd_col)))
    else $error("burst start column not captured");

  // sequential steps by one modulo the block
  chk_seq_step: assert property (
    @(posedge clock) disable iff (rst || !clk_en)
    burst_act && !ilv_ff && $past(burst_act) && !$past(rd_go || wr_go)
      |-> ((cur_col & mask_ff) ==
           (($past(cur_col) + COL_W'(1)) & mask_ff)))
    else $error("sequential burst skipped a column");

  // interleaved offset equals start xor index
  chk_ilv_order: assert property (
    @(posedge clock) disable iff (rst || !clk_en)
    burst_act && ilv_ff
      |-> (((cur_col ^ start_ff) & mask_ff) ==
           (idx_ff[COL_W-1:0] & mask_ff)))
    else $error("interleaved burst out of order");

  // never more accesses than the programmed length
  chk_burst_cap: assert property (
    @(posedge clock) disable iff (rst || !clk_en)
    words_ff <= len_ff)
    else $error("burst ran past its length");

  // single write mode ends the write at once
  chk_write_one: assert property (
    @(posedge clock) disable iff (rst || !clk_en)
    wr_go && wsa_sel |=> !burst_act ##0 (len_ff == LEN_ONE))
    else $error("single write mode ran a burst");

  // write burst keeps the programmed length when single bit clear
  chk_write_len: assert property (
    @(posedge clock) disable iff (rst || !clk_en)
    wr_go && !wsa_sel |=> (len_ff == $past(burst_len)))
    else $error("write burst length not programmed length");

  // terminate stops the burst on the next edge
  chk_term_stop: assert property (
    @(posedge clock) disable iff (rst || !clk_en)
    cmd_term && !cmd_read && !cmd_write |=> !burst_act)
    else $error("burst survived terminate");

  // outside normal mode commands start nothing
  chk_mode_gate: assert property (
    @(posedge clock) disable iff (rst || !clk_en)
    !op_normal && !burst_act && (cmd_read || cmd_write)
      |=> !burst_act && !iss_ff)
    else $error("command acted outside normal mode");

  // index climbs by one each edge of a running burst
  chk_idx_step: assert property (
    @(posedge clock) disable iff (rst || !clk_en)
    burst_act && !rd_go && !wr_go |=> (idx_ff == $past(idx_ff) + LEN_ONE))
    else $error("burst index did not advance");

  // full page is always sequential
  chk_page_seq: assert property (
    @(posedge clock) disable iff (rst || !clk_en)
    page_sel |-> !ilv_sel)
    else $error("full page took interleaved order");

endmodule // sdbs_top

// *** sdbs_ctl_model.sv ***
/*
  sdbs_ctl_model: behavioural memory controller for the burst block.
  Drives read, write and terminate commands plus write data.
  Assumes the testbench calls one task at a time on a free-running clock.
*/
`timescale 1ns/1ps
module sdbs_ctl_model import sdbs_pkg::*; #(
  parameter int COL_W = 9,
  parameter int DQ_W = 16
) (
  // clocking
  input wire logic clock,
  // commands
  output logic cmd_read,
  output logic cmd_write,
  output logic cmd_term,
  output logic [COL_W-1:0] cmd_col,
  // write data
  output logic [DQ_W-1:0] dq_in
);
  // quiet command bus at time zero
  initial begin
    cmd_read = 1'b0;
    cmd_write = 1'b0;
    cmd_term = 1'b0;
    cmd_col = '0;
    dq_in = '0;
  end

  // terminate t edges after the command edge, none when t is zero
  task automatic term_after(input int t);
    if (t > 0) begin
      repeat (t - 1) @(posedge clock);
      cmd_term <= 1'b1;
      @(posedge clock);
      cmd_term <= 1'b0;
    end
  endtask

  // one read; the column bus is inverted once released
  task automatic rd(input logic [COL_W-1:0] c, input int t);
    @(posedge clock);
    cmd_read <= 1'b1;
    cmd_col <= c;
    @(posedge clock);
    cmd_read <= 1'b0;
    cmd_col <= ~c;
    term_after(t);
  endtask

  // write burst of nw words; one stray word follows at edge n+nw
  task automatic wr(input logic [COL_W-1:0] c, input int nw,
                    input logic [DQ_W-1:0] d0, input bit term);
    @(posedge clock);
    cmd_write <= 1'b1;
    cmd_col <= c;
    dq_in <= d0;
    for (int i = 1; i <= nw; i++) begin
      @(posedge clock);
      cmd_write <= 1'b0;
      cmd_col <= ~c;
      dq_in <= d0 + DQ_W'(i);
      if (i == nw && term) begin
        cmd_term <= 1'b1;
      end
    end
    @(posedge clock);
    cmd_term <= 1'b0;
    dq_in <= ~dq_in;  // released data shows no stale word
  endtask
endmodule // sdbs_ctl_model

// *** tb_sdbs_top.sv ***
/*
  tb_sdbs_top: self-checking bench for the burst sequencing block.
  Assumes the controller model drives commands and the bench owns the
  register port; expected memory contents are kept in mem_exp.
*/
`timescale 1ns/1ps
module tb_sdbs_top import sdbs_pkg::*;;
  logic clock;
  logic rst;
  logic clk_en;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata_ff;
  logic reg_wr;
  logic reg_rd;
  logic cmd_read;
  logic cmd_write;
  logic cmd_term;
  logic [8:0] cmd_col;
  logic [15:0] dq_in;
  logic [15:0] dq_out_ff;
  logic dq_oe_ff;
  logic [15:0] mem_exp [512];
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // bl, interleaved, latency, start column
  int tbl [6][4] = '{'{1, 0, 2, 1}, '{2, 0, 3, 3}, '{2, 1, 2, 1},
                     '{3, 1, 3, 13}, '{3, 0, 2, 6}, '{0, 1, 3, 9}};

  sdbs_top uut (.clock(clock), .rst(rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .cmd_read(cmd_read),
    .cmd_write(cmd_write), .cmd_term(cmd_term), .cmd_col(cmd_col),
    .dq_in(dq_in), .dq_out_ff(dq_out_ff), .dq_oe_ff(dq_oe_ff));

  sdbs_ctl_model u_ctl (.clock(clock), .cmd_read(cmd_read),
    .cmd_write(cmd_write), .cmd_term(cmd_term), .cmd_col(cmd_col),
    .dq_in(dq_in));

  // free-running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count = fail_count + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // register port cycles
  task automatic reg_w(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_r(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(reg_rdata_ff, e);
  endtask

  function automatic logic [31:0] mode_w(input int bl, ilv, lat, opm, wsa);
    return 32'(bl) | (32'(ilv) << SDBS_BO_POS) | (32'(lat) << SDBS_LAT_POS)
      | (32'(opm) << SDBS_OPL_POS) | (32'(wsa) << SDBS_WSA_POS);
  endfunction

  // upper junk bits must be dropped on write
  task automatic set_mode(input logic [31:0] m);
    reg_w(SDBS_REG_MODE_OFS, m | 32'hABCD_FC00);
    reg_r(SDBS_REG_MODE_OFS, m);
  endtask

  function automatic int col_of(input int s, k, len, ilv);
    if (len == 512) return (s + k) % 512;
    if (ilv != 0) return (s & ~(len - 1)) | ((s % len) ^ k);
    return (s & ~(len - 1)) | ((s + k) % len);
  endfunction

  // watch a read burst: enable timing, words and order
  task automatic chk_rd(input int s, len, ilv, m, cnt);
    repeat (m) @(posedge clock);
    @(negedge clock);
    chk(32'(dq_oe_ff), 32'h0000_0000);
    for (int k = 0; k < cnt; k++) begin
      @(posedge clock);
      @(negedge clock);
      chk(32'(dq_oe_ff), 32'h0000_0001);
      chk(32'(dq_out_ff), 32'(mem_exp[col_of(s, k, len, ilv)]));
    end
    @(posedge clock);
    @(negedge clock);
    chk(32'(dq_oe_ff), 32'h0000_0000);
  endtask

  task automatic rd_chk(input int s, len, ilv, m, t, cnt);
    fork
      u_ctl.rd(9'(s), t);
      chk_rd(s, len, ilv, m, cnt);
    join
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    reg_r(SDBS_REG_MODE_OFS, 32'(SDBS_MODE_RST));
    reg_r(8'h08, 32'h0000_0000);
    chk(32'(dq_oe_ff), 32'h0000_0000);
    $display("test reset done");
    // fill two aligned blocks, the second from a wrapping start
    set_mode(mode_w(3, 0, 2, 0, 0));
    u_ctl.wr(9'h000, 8, 16'h1000, 1'b0);
    u_ctl.wr(9'h00B, 8, 16'h2000, 1'b0);
    for (int k = 0; k < 8; k++) begin
      mem_exp[k] = 16'h1000 + 16'(k);
      mem_exp[col_of(11, k, 8, 0)] = 16'h2000 + 16'(k);
    end
    // lengths one, two, four and eight, both orders, both latencies
    for (int i = 0; i < 6; i++) begin
      set_mode(mode_w(tbl[i][0], tbl[i][1], tbl[i][2], 0, 0));
      rd_chk(tbl[i][3], 1 << tbl[i][0], tbl[i][1], tbl[i][2], 0,
             1 << tbl[i][0]);
    end
    $display("test burst order done");
    // full page across the page edge, cut short by terminate
    set_mode(mode_w(7, 0, 2, 0, 0));
    u_ctl.wr(9'h1FE, 4, 16'h3000, 1'b1);
    for (int k = 0; k < 4; k++) begin
      mem_exp[col_of(510, k, 512, 0)] = 16'h3000 + 16'(k);
    end
    rd_chk(510, 512, 0, 2, 5, 5);
    // order select set with full page still runs sequential
    set_mode(mode_w(7, 1, 2, 0, 0));
    rd_chk(510, 512, 0, 2, 3, 3);
    $display("test full page done");
    // single-location writes, burst reads
    set_mode(mode_w(2, 0, 3, 0, 1));
    u_ctl.wr(9'h004, 4, 16'h4000, 1'b0);
    mem_exp[4] = 16'h4000;
    rd_chk(4, 4, 0, 3, 0, 4);
    $display("test write single done");
    // reserved operating modes ignore commands
    for (int o = 1; o < 4; o++) begin
      set_mode(mode_w(2, 0, 2, o, 0));
      u_ctl.wr(9'h000, 4, 16'h5000, 1'b0);
    end
    fork
      u_ctl.rd(9'h000, 0);
      repeat (6) begin
        @(negedge clock);
        chk(32'(dq_oe_ff), 32'h0000_0000);
      end
    join
    set_mode(mode_w(2, 0, 2, 0, 0));
    rd_chk(0, 4, 0, 2, 0, 4);
    $display("test op mode done");
    // reserved length acts as one access and is flagged in status
    set_mode(mode_w(5, 0, 2, 0, 0));
    rd_chk(2, 1, 0, 2, 0, 1);
    reg_r(SDBS_REG_STAT_OFS, 32'h0002_0008);
    $display("test reserved length done");
    stop_test();
  end
endmodule // tb_sdbs_top
